// >>> hdl/chan_route.sv
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "chan_route_regs.svh"

module chan_route
  import chan_route_pkg::*;
(
  // Clock and reset
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST_N,
  // AXI4-Lite register slave
  input  wire logic [7:0]               S_AXI_AWADDR,
  input  wire logic                     S_AXI_AWVALID,
  output logic                          S_AXI_AWREADY,
  input  wire logic [31:0]              S_AXI_WDATA,
  input  wire logic [3:0]               S_AXI_WSTRB,
  input  wire logic                     S_AXI_WVALID,
  output logic                          S_AXI_WREADY,
  output logic [1:0]                    S_AXI_BRESP,
  output logic                          S_AXI_BVALID,
  input  wire logic                     S_AXI_BREADY,
  input  wire logic [7:0]               S_AXI_ARADDR,
  input  wire logic                     S_AXI_ARVALID,
  output logic                          S_AXI_ARREADY,
  output logic [31:0]                   S_AXI_RDATA,
  output logic [1:0]                    S_AXI_RRESP,
  output logic                          S_AXI_RVALID,
  input  wire logic                     S_AXI_RREADY,
  // Receive alarms
  input  wire logic                     RX_LOS,
  input  wire logic                     RX_LOT,
  input  wire logic                     RX_LOF,
  input  wire logic                     RX_LAIS,
  input  wire logic                     RX_LOP,
  input  wire logic                     RX_PAIS,
  input  wire logic                     RX_LOPC,
  input  wire logic                     RX_AISC,
  // Serial line
  input  wire logic                     RX_LINE_BIT,
  output logic                          TX_LINE_BIT,
  output logic                          TX_LINE_VALID,
  output logic                          RX_DESER_BIT,
  output chan_route_pkg::timing_src_e   TX_TIMING_SRC,
  output logic                          BYTE_EN,
  // Byte streams from processors
  input  wire chan_route_pkg::byte_t    TX_SOH_BYTE,
  input  wire chan_route_pkg::byte_t    RX_DESER_BYTE,
  input  wire chan_route_pkg::byte_t    TX_POH_BYTE,
  input  wire chan_route_pkg::byte_t    RX_LOH_BYTE,
  input  wire chan_route_pkg::byte_t    TX_CELL_BYTE,
  input  wire chan_route_pkg::byte_t    RX_POH_OUT_BYTE,
  input  wire logic                     RX_PTR_VALID,
  // Byte streams to processors
  output chan_route_pkg::byte_t         RX_SOH_BYTE,
  output chan_route_pkg::byte_t         RX_POH_BYTE,
  output chan_route_pkg::byte_t         TX_LOH_BYTE,
  output chan_route_pkg::byte_t         RX_CELL_BYTE,
  // Other channel and protection link
  input  wire chan_route_pkg::byte_t    OTHER_CH_BYTE,
  input  wire logic                     OTHER_CH_VALID,
  input  wire chan_route_pkg::byte_t    LINK_RX_BYTE,
  input  wire logic                     LINK_DL_LIMIT,
  input  wire logic                     LINK_FRAME_START,
  input  wire logic                     LINK_DCC_SLOT,
  input  wire logic                     LINK_BIP_SLOT,
  output logic                          LINK_TX_BIT
);
  import chan_route_pkg::*;

  // ========================================================================
  // Register bus
  logic [`CFG_WIDTH-1:0] cfg_q;
  logic                  aw_got_q;
  logic                  w_got_q;
  logic [7:0]            aw_addr_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  fifo_rst_q;
  logic                  limit_flag_q;
  logic                  ais_q;
  logic                  do_write;
  logic                  clear_limit;
  logic [31:0]           rd_word;
  logic                  rd_hit;
  fifo_ptr_t             wr_ptr_q;
  fifo_ptr_t             rd_ptr_q;
  fifo_ptr_t             fill;

  assign do_write    = aw_got_q && w_got_q && !S_AXI_BVALID;
  assign clear_limit = do_write && aw_addr_q == `REG_STATUS_ADDR && w_strb_q[0] && w_data_q[`STS_LIMIT_FLAG];
  assign fill        = fifo_ptr_t'(wr_ptr_q - rd_ptr_q);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      `REG_CONFIG_ADDR:    rd_word[`CFG_WIDTH-1:0] = cfg_q;
      `REG_FIFO_CTRL_ADDR: rd_word = 32'h0000_0000;
      `REG_STATUS_ADDR: begin
        rd_word[`STS_LIMIT_FLAG]                   = limit_flag_q;
        rd_word[`STS_AIS_FORCED]                   = ais_q;
        rd_word[`STS_RECOVERED_CLK]                = TX_TIMING_SRC == TS_RECOVERED;
        rd_word[`STS_FILL_LSB+2:`STS_FILL_LSB]     = fill;
      end
      default:             rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_got_q && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_got_q && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q  <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_q == `REG_CONFIG_ADDR || aw_addr_q == `REG_FIFO_CTRL_ADDR ||
                         aw_addr_q == `REG_STATUS_ADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `RESP_OKAY;
    end else if (S_AXI_RVALID) begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Configuration; one bit per loopback keeps channels independent
  // loopback enables
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cfg_q <= `CFG_RESET;
    end else if (do_write && aw_addr_q == `REG_CONFIG_ADDR) begin
      if (w_strb_q[0]) cfg_q[7:0]            <= w_data_q[7:0];
      if (w_strb_q[1]) cfg_q[`CFG_WIDTH-1:8] <= w_data_q[`CFG_WIDTH-1:8];
    end
  end

  // Self-clearing pulse so software need not write it back
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      fifo_rst_q <= 1'b0;
    end else begin
      fifo_rst_q <= do_write && aw_addr_q == `REG_FIFO_CTRL_ADDR && w_strb_q[0] && w_data_q[`FCTL_FIFO_RESET];
    end
  end

  // ========================================================================
  // Timing
  logic [2:0] bit_cnt_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bit_cnt_q <= 3'd0;
      BYTE_EN   <= 1'b0;
    end else begin
      bit_cnt_q <= (bit_cnt_q == `CSU_MULT) ? 3'd0 : bit_cnt_q + 3'd1;
      BYTE_EN   <= bit_cnt_q == `CSU_MULT;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      TX_TIMING_SRC <= TS_REFERENCE;
    end else if (cfg_q[`CFG_RECOVERED_TIMING] && !RX_LOS && !RX_LOT) begin
      TX_TIMING_SRC <= TS_RECOVERED;
    end else begin
      TX_TIMING_SRC <= TS_REFERENCE;
    end
  end

  // ========================================================================
  // Channel FIFO
  byte_t chf_mem_q [8];
  byte_t chf_out;

  assign chf_out = chf_mem_q[rd_ptr_q];

  // eight-byte crossing; recentre on reset pulse
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || fifo_rst_q) begin
      wr_ptr_q <= `CHF_CENTER;
      rd_ptr_q <= 3'h0;
    end else begin
      if (OTHER_CH_VALID) wr_ptr_q <= wr_ptr_q + 3'h1;
      if (BYTE_EN)        rd_ptr_q <= rd_ptr_q + 3'h1;
    end
  end

  generate
    for (genvar i = 0; i < 8; i++) begin : g_chf
      always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
          chf_mem_q[i] <= 8'h00;
        end else if (OTHER_CH_VALID && wr_ptr_q == fifo_ptr_t'(i)) begin
          chf_mem_q[i] <= OTHER_CH_BYTE;
        end
      end
    end
  endgenerate

  // ========================================================================
  // Path routing
  byte_t tx_path;
  byte_t prot_tx;
  byte_t prot_rx;

  assign prot_tx = cfg_q[`CFG_TX_SRC_SEL] ? LINK_RX_BYTE : chf_out;
  assign prot_rx = cfg_q[`CFG_RX_SRC_SEL] ? LINK_RX_BYTE : chf_out;
  assign tx_path = cfg_q[`CFG_TX_PROT_EN] ? prot_tx : TX_POH_BYTE;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RX_SOH_BYTE  <= 8'h00;
      RX_POH_BYTE  <= 8'h00;
      TX_LOH_BYTE  <= 8'h00;
      RX_CELL_BYTE <= 8'h00;
    end else if (BYTE_EN) begin
      TX_LOH_BYTE  <= tx_path;
      RX_SOH_BYTE  <= cfg_q[`CFG_PARALLEL_DIAG] ? TX_SOH_BYTE : RX_DESER_BYTE;
      // path loop includes protection stream; receive select
      if (cfg_q[`CFG_PATH_DIAG])       RX_POH_BYTE <= tx_path;
      else if (cfg_q[`CFG_RX_PROT_EN]) RX_POH_BYTE <= prot_rx;
      else                             RX_POH_BYTE <= RX_LOH_BYTE;
      RX_CELL_BYTE <= cfg_q[`CFG_DATA_DIAG] ? TX_CELL_BYTE : RX_POH_OUT_BYTE;
    end
  end

  // ========================================================================
  // Serial line and loopbacks
  byte_t line_ser_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      line_ser_q <= 8'h00;
    end else if (BYTE_EN) begin
      line_ser_q <= TX_SOH_BYTE;
    end else begin
      line_ser_q <= {line_ser_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      TX_LINE_BIT   <= 1'b0;
      TX_LINE_VALID <= 1'b0;
      RX_DESER_BIT  <= 1'b0;
    end else begin
      // line loop; receive side keeps running
      TX_LINE_BIT   <= cfg_q[`CFG_LINE_LOOP] ? RX_LINE_BIT : line_ser_q[7];
      // line output invalid in data loop
      TX_LINE_VALID <= !cfg_q[`CFG_DATA_DIAG];
      RX_DESER_BIT  <= cfg_q[`CFG_SERIAL_DIAG] ? line_ser_q[7] : RX_LINE_BIT;
    end
  end

  // ========================================================================
  // Transmit protection link
  byte_t  rx_retimed_q;
  byte_t  link_plain;
  byte_t  link_scr;
  byte_t  bip_q;
  byte_t  bip_hold_q;
  byte_t  link_ser_q;
  logic [6:0] scr_q;
  logic [14:0] scr_nxt;
  logic       rx_invalid;

  function automatic logic [14:0] scr_step(input logic [6:0] st);
    logic [6:0] s;
    logic [7:0] k;
    s = st;
    k = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      k[b] = s[6];
      s    = {s[5:0], s[6] ^ s[5]};
    end
    return {s, k};
  endfunction : scr_step

  // A select cannot follow a function call, so the step result is a net
  assign scr_nxt    = scr_step(scr_q);
  assign rx_invalid = RX_LOP || RX_LOS || RX_PAIS || RX_LOPC || RX_AISC;

  // hold last byte while the pointer is not valid
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_retimed_q <= 8'h00;
    end else if (BYTE_EN && RX_PTR_VALID) begin
      rx_retimed_q <= RX_POH_OUT_BYTE;
    end
  end

  always_comb begin
    if (LINK_DCC_SLOT) begin
      link_plain = {5'b00000, RX_LOS, RX_LOF, RX_LAIS};
    end else if (LINK_BIP_SLOT) begin
      link_plain = bip_hold_q;
    end else if (cfg_q[`CFG_LINK_CONTENT]) begin
      link_plain = rx_invalid ? `AIS_BYTE : rx_retimed_q;
    end else begin
      link_plain = tx_path;
    end
  end

  assign link_scr = link_plain ^ scr_nxt[7:0];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      scr_q      <= `SCR_SEED;
      bip_q      <= 8'h00;
      bip_hold_q <= 8'h00;
      link_ser_q <= 8'h00;
      ais_q      <= 1'b0;
    end else if (BYTE_EN) begin
      link_ser_q <= link_scr;
      ais_q      <= cfg_q[`CFG_LINK_CONTENT] && rx_invalid;
      if (LINK_FRAME_START) begin
        scr_q      <= `SCR_SEED;
        bip_hold_q <= bip_q;
        bip_q      <= link_scr;
      end else begin
        scr_q <= scr_nxt[14:8];
        bip_q <= bip_q ^ link_scr;
      end
    end else begin
      link_ser_q <= {link_ser_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      LINK_TX_BIT <= 1'b0;
    end else begin
      LINK_TX_BIT <= link_ser_q[7];
    end
  end

  // sticky limit flag, set beats clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      limit_flag_q <= 1'b0;
    end else if (LINK_DL_LIMIT) begin
      limit_flag_q <= 1'b1;
    end else if (clear_limit) begin
      limit_flag_q <= 1'b0;
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_byte_gap;
    !BYTE_EN [*7] ##1 BYTE_EN;
  endsequence

  property p_byte_period;
    BYTE_EN |=> s_byte_gap;
  endproperty
  a_byte_period: assert property (p_byte_period) else $error("byte enable period wrong");

  property p_timing_src;
    ##1 (TX_TIMING_SRC == TS_RECOVERED) == $past(cfg_q[`CFG_RECOVERED_TIMING] && !RX_LOS && !RX_LOT);
  endproperty
  a_timing_src: assert property (p_timing_src) else $error("timing source wrong");

  property p_line_loop;
    cfg_q[`CFG_LINE_LOOP] |=> TX_LINE_BIT == $past(RX_LINE_BIT);
  endproperty
  a_line_loop: assert property (p_line_loop) else $error("line loop data wrong");

  property p_serial_loop;
    cfg_q[`CFG_SERIAL_DIAG] |=> RX_DESER_BIT == $past(line_ser_q[7]);
  endproperty
  a_serial_loop: assert property (p_serial_loop) else $error("serial loop data wrong");

  property p_par_loop;
    BYTE_EN && cfg_q[`CFG_PARALLEL_DIAG] |=> RX_SOH_BYTE == $past(TX_SOH_BYTE);
  endproperty
  a_par_loop: assert property (p_par_loop) else $error("parallel loop byte wrong");

  property p_path_loop;
    BYTE_EN && cfg_q[`CFG_PATH_DIAG] |=> RX_POH_BYTE == $past(tx_path);
  endproperty
  a_path_loop: assert property (p_path_loop) else $error("path loop byte wrong");

  property p_data_loop;
    cfg_q[`CFG_DATA_DIAG] [*2] |-> !TX_LINE_VALID;
  endproperty
  a_data_loop: assert property (p_data_loop) else $error("line valid in data loop");

  property p_ais;
    BYTE_EN && cfg_q[`CFG_LINK_CONTENT] && rx_invalid && !LINK_DCC_SLOT && !LINK_BIP_SLOT
      |=> link_ser_q == ($past(scr_nxt[7:0]) ^ `AIS_BYTE) && ais_q;
  endproperty
  a_ais: assert property (p_ais) else $error("AIS not forced");

  property p_limit;
    LINK_DL_LIMIT |=> limit_flag_q;
  endproperty
  a_limit: assert property (p_limit) else $error("limit flag lost");

  property p_fifo_center;
    fifo_rst_q |=> fill == `CHF_CENTER;
  endproperty
  a_fifo_center: assert property (p_fifo_center) else $error("FIFO not recentred");

endmodule : chan_route

// >>> hdl/chan_route_regs.svh
`ifndef CHAN_ROUTE_REGS_SVH
`define CHAN_ROUTE_REGS_SVH

// ==========================================================================
// Register byte addresses
`define REG_CONFIG_ADDR     8'h00
`define REG_FIFO_CTRL_ADDR  8'h04
`define REG_STATUS_ADDR     8'h08

// ==========================================================================
// Configuration register fields
`define CFG_RECOVERED_TIMING 0
`define CFG_LINE_LOOP        1
`define CFG_SERIAL_DIAG      2
`define CFG_PARALLEL_DIAG    3
`define CFG_PATH_DIAG        4
`define CFG_DATA_DIAG        5
`define CFG_TX_PROT_EN       6
`define CFG_RX_PROT_EN       7
`define CFG_TX_SRC_SEL       8
`define CFG_RX_SRC_SEL       9
`define CFG_LINK_CONTENT     10
`define CFG_WIDTH            11
`define CFG_RESET            11'h000

// ==========================================================================
// FIFO control and status fields
`define FCTL_FIFO_RESET      0
`define STS_LIMIT_FLAG       0
`define STS_AIS_FORCED       1
`define STS_RECOVERED_CLK    2
`define STS_FILL_LSB         4

// ==========================================================================
// Timing, datapath and bus response constants
`define CSU_MULT             3'd7
`define CHF_CENTER           3'h4
`define SCR_SEED             7'h7F
`define AIS_BYTE             8'hFF
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// >>> hdl/chan_route_pkg.sv
package chan_route_pkg;
  // Transmit clock origin
  typedef enum logic [0:0] {
    TS_REFERENCE = 1'b0,
    TS_RECOVERED = 1'b1
  } timing_src_e;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] fifo_ptr_t;
endpackage : chan_route_pkg

// >>> sim/peer_link_model.sv
`timescale 1ns/1ns
// ==========
// Peer framer seen across the protection link
module peer_link_model
  import chan_route_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Local byte timing and stimulus
  input  wire logic                  byte_en,
  input  wire chan_route_pkg::byte_t link_val,
  input  wire logic                  dl_req,
  // Recovered link towards the block
  output chan_route_pkg::byte_t      link_byte,
  output logic                       frame_start,
  output logic                       dcc_slot,
  output logic                       bip_slot,
  output logic                       dl_limit
);
  logic [3:0] slot_q;

  always_ff @(posedge clk) begin
    if (!rst_n) slot_q <= 4'h0;
    else if (byte_en) slot_q <= slot_q + 4'h1;
  end
  assign frame_start = (slot_q == 4'h0);
  assign dcc_slot    = (slot_q == 4'h1);
  assign bip_slot    = (slot_q == 4'h2);
  assign link_byte   = link_val;
  always_ff @(posedge clk) dl_limit <= rst_n & dl_req;
endmodule : peer_link_model

// >>> sim/tb.sv
`timescale 1ns/1ns
`include "chan_route_regs.svh"
module tb;
  import chan_route_pkg::*;
  logic        clk, rst_n, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv;
  logic [7:0]  awa, ara, tq, dq;
  logic [31:0] wd, rd, sd, lf;
  logic [1:0]  br, rr, rs;
  logic [4:0]  alm;
  logic        lot, lof, lais, lb, dlq, txb, txv, dsb, be, ltx, fs, dcc, bip, dll;
  timing_src_e ts;
  byte_t       soh, dsr, poh, loh, cel, rpo, oth, lv, lkb, o_soh, o_poh, o_loh, o_cel;
  int          errors, compares, cyc, cfg, k;
  int          tbl [10] = '{0, 8, 16, 32, 128, 640, 64, 320, 960, 1024};

  chan_route dut (.SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .RX_LOS(alm[1]), .RX_LOT(lot),
    .RX_LOF(lof), .RX_LAIS(lais), .RX_LOP(alm[0]), .RX_PAIS(alm[2]), .RX_LOPC(alm[3]), .RX_AISC(alm[4]),
    .RX_LINE_BIT(lb), .TX_LINE_BIT(txb), .TX_LINE_VALID(txv), .RX_DESER_BIT(dsb), .TX_TIMING_SRC(ts),
    .BYTE_EN(be), .TX_SOH_BYTE(soh), .RX_DESER_BYTE(dsr), .TX_POH_BYTE(poh), .RX_LOH_BYTE(loh),
    .TX_CELL_BYTE(cel), .RX_POH_OUT_BYTE(rpo), .RX_PTR_VALID(1'b1), .RX_SOH_BYTE(o_soh), .RX_POH_BYTE(o_poh),
    .TX_LOH_BYTE(o_loh), .RX_CELL_BYTE(o_cel), .OTHER_CH_BYTE(oth), .OTHER_CH_VALID(1'b1), .LINK_RX_BYTE(lkb),
    .LINK_DL_LIMIT(dll), .LINK_FRAME_START(fs), .LINK_DCC_SLOT(dcc), .LINK_BIP_SLOT(bip), .LINK_TX_BIT(ltx));

  peer_link_model peer (.clk(clk), .rst_n(rst_n), .byte_en(be), .link_val(lv), .dl_req(dlq), .link_byte(lkb),
    .frame_start(fs), .dcc_slot(dcc), .bip_slot(bip), .dl_limit(dll));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  // Serial windows are unaligned, so accept any rotation
  function automatic logic rot(input byte_t a, input byte_t b);
    logic [15:0] d;
    d = {a, a};
    for (int j = 0; j < 8; j++) if (d[j+:8] == b) return 1'b1;
    return 1'b0;
  endfunction : rot

  function automatic byte_t e_poh();
    if (cfg[`CFG_PATH_DIAG]) return poh;
    if (!cfg[`CFG_RX_PROT_EN]) return loh;
    return cfg[`CFG_RX_SRC_SEL] ? lv : oth;
  endfunction : e_poh

  function automatic byte_t e_loh();
    if (!cfg[`CFG_TX_PROT_EN]) return poh;
    return cfg[`CFG_TX_SRC_SEL] ? lv : oth;
  endfunction : e_loh

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk);
      ah = awv & awr;
      wh = wv & wr;
      bh = bv;
      rs = br;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    brdy <= 1'b0;
    @(posedge clk);
  endtask : axw

  task axr(input logic [7:0] a);
    logic ah, dh;
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    dh = 1'b0;
    while (!dh) begin
      @(negedge clk);
      ah = arv & arr;
      dh = rv;
      sd = rd;
      rs = rr;
      @(posedge clk);
      if (ah) arv <= 1'b0;
    end
    rrdy <= 1'b0;
    @(posedge clk);
  endtask : axr

  task setc(input int v);
    cfg = v;
    axw(`REG_CONFIG_ADDR, v);
    chk("cfg_resp", `RESP_OKAY, rs);
  endtask : setc

  task rnd();
    repeat (32) lf = nx(lf);
    soh <= lf[7:0];
    dsr <= lf[15:8];
    poh <= lf[23:16];
    loh <= lf[31:24];
    repeat (32) lf = nx(lf);
    cel <= lf[7:0];
    rpo <= lf[15:8];
    lv <= lf[23:16];
    lof <= lf[24];
    lais <= lf[25];
  endtask : rnd

  task tally_and_finish();
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial begin
    {awv, wv, brdy, arv, rrdy, dlq, lot, lof, lais, lb} = '0;
    {awa, ara, wd, alm, soh, dsr, poh, loh, cel, rpo, lv} = '0;
    {errors, compares, cyc, cfg} = '0;
    lf = 32'hE2E97D1F;
    oth = 8'h3C;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    axr(`REG_CONFIG_ADDR);
    chk("cfg_rst", `CFG_RESET, sd);
    axw(8'h0C, 32'h1);
    chk("unm_wr", `RESP_SLVERR, rs);
    axr(8'h0C);
    chk("unm_rd", `RESP_SLVERR, rs);
    chk("unm_data", 32'h0, sd);
    lf = nx(lf);
    setc(lf[10:0]);
    axr(`REG_CONFIG_ADDR);
    chk("cfg_rb", lf[10:0], sd);
    do @(negedge clk); while (be !== 1'b1);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (be !== 1'b1);
    chk("byte_period", 8, k);
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      setc(i & 1);
      alm[1] <= i[1];
      lot <= i[2];
      repeat (4) @(posedge clk);
      chk("tsrc", i == 1, ts);
      axr(`REG_STATUS_ADDR);
      chk("sts_rec", i == 1, sd[`STS_RECOVERED_CLK]);
    end
    alm <= '0;
    lot <= 1'b0;
    axw(`REG_FIFO_CTRL_ADDR, 32'h1);
    for (int i = 0; i < 10; i++) begin
      rnd();
      setc(tbl[i]);
      repeat (20) @(posedge clk);
      chk("rx_soh", cfg[3] ? soh : dsr, o_soh);
      chk("rx_poh", e_poh(), o_poh);
      chk("tx_loh", e_loh(), o_loh);
      chk("rx_cel", cfg[5] ? cel : rpo, o_cel);
      chk("tx_val", !cfg[5], txv);
    end
    setc(2);
    for (k = 0; k < 24; k++) begin
      lf = nx(lf);
      @(posedge clk);
      lb <= lf[0];
      tq = {tq[6:0], lf[0]};
      @(negedge clk);
      if (k > 0) chk("line_loop", tq[1], txb);
    end
    @(posedge clk);
    lb <= 1'b0;
    soh <= {1'b0, lf[6:1], 1'b1};
    setc(4);
    repeat (24) @(posedge clk);
    for (k = 0; k < 8; k++) begin
      @(negedge clk);
      tq = {tq[6:0], txb};
      dq = {dq[6:0], dsb};
    end
    chk("ser_tx", 1, rot(tq, soh));
    chk("ser_loop", 1, rot(dq, soh));
    chk("ser_val", 1, txv);
    @(posedge clk);
    setc(1024);
    for (int i = 0; i < 5; i++) begin
      alm <= 5'h1 << i;
      repeat (16) @(posedge clk);
      axr(`REG_STATUS_ADDR);
      chk("ais_on", 1, sd[`STS_AIS_FORCED]);
    end
    alm <= '0;
    repeat (16) @(posedge clk);
    axr(`REG_STATUS_ADDR);
    chk("ais_off", 0, sd[`STS_AIS_FORCED]);
    dlq <= 1'b1;
    @(posedge clk);
    dlq <= 1'b0;
    repeat (4) @(posedge clk);
    axr(`REG_STATUS_ADDR);
    chk("dl_set", 1, sd[`STS_LIMIT_FLAG]);
    axw(`REG_STATUS_ADDR, 32'h1);
    axr(`REG_STATUS_ADDR);
    chk("dl_clr", 0, sd[`STS_LIMIT_FLAG]);
    tally_and_finish();
  end
endmodule : tb
